// file: rtl/spi_fe_top.sv
// Serial front end of an SPI memory: pin sampling, shifting, select and hold.
`timescale 1ns/100ps
`default_nettype none
module spi_fe_top
  import spi_fe_pkg::*;
#(
  parameter int unsigned DEPTH = spi_fe_pkg::BUF_DEPTH
) (
  input  wire logic                      i_clk,
  input  wire logic                      i_resetn,
  // Pins from the bus master.
  input  wire logic                      i_sclk,
  input  wire logic                      i_sdi,
  input  wire logic                      i_cs_n,
  input  wire logic                      i_hold_n,
  input  wire logic                      i_wp_n,
  output var  logic                      o_sdo,
  output var  logic                      o_sdo_oe_n,
  // Received bytes toward the command logic.
  output var  logic                      o_rx_valid,
  output var  logic [spi_fe_pkg::BYTE_W-1:0] o_rx_data,
  output var  logic                      o_rx_first,
  input  wire logic                      i_rx_ready,
  output var  logic                      o_rx_overrun,
  // Bytes to send, taken at each byte boundary after the first byte.
  input  wire logic                      i_tx_valid,
  input  wire logic [spi_fe_pkg::BYTE_W-1:0] i_tx_data,
  output var  logic                      o_tx_ready,
  // Command logic verdict on the instruction byte.
  input  wire logic                      i_cmd_reject,
  // Frame end report.
  output var  logic                      o_frame_end,
  output var  logic                      o_frame_accept,
  // Status bits.
  input  wire logic                      i_wel_set,
  input  wire logic                      i_wel_clr,
  input  wire logic                      i_write_start,
  input  wire logic                      i_write_done,
  input  wire logic                      i_status_write_disable,
  input  wire logic                      i_block_protect_hi,
  input  wire logic                      i_block_protect_lo,
  output var  logic                      o_write_enable_latch,
  output var  logic                      o_write_in_progress,
  output var  logic                      o_protect_frozen,
  output var  logic [1:0]                o_block_protect,
  output var  logic                      o_selected,
  output var  logic                      o_standby
);

  initial
  begin
    if (DEPTH < 2)
    begin
      $error("spi_fe_top: DEPTH must be at least 2");
    end
  end

  // Pin synchronisers; select and hold idle high while in reset.
  logic [SYNC_W-1:0] pins_sync;
  logic              sclk_s;
  logic              sdi_s;
  logic              cs_n_s;
  logic              hold_n_s;
  logic              wp_n_s;

  spi_fe_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .i_clk     (i_clk),
    .i_resetn  (i_resetn),
    .i_async   ({i_wp_n, i_hold_n, i_cs_n, i_sdi, i_sclk}),
    .i_rst_val (5'h1E),
    .o_sync    (pins_sync)
  );

  assign sclk_s   = pins_sync[0];
  assign sdi_s    = pins_sync[1];
  assign cs_n_s   = pins_sync[2];
  assign hold_n_s = pins_sync[3];
  assign wp_n_s   = pins_sync[4];

  fe_state_e              state_reg;
  fe_state_e              state_next;
  logic                   sclk_prev_reg;
  logic                   sclk_prev_next;
  logic                   cs_prev_reg;
  logic                   cs_prev_next;
  logic [BYTE_W-1:0]      rx_shift_reg;
  logic [BYTE_W-1:0]      rx_shift_next;
  logic [BIT_CNT_W-1:0]   bit_cnt_reg;
  logic [BIT_CNT_W-1:0]   bit_cnt_next;
  logic                   first_byte_reg;
  logic                   first_byte_next;
  logic [BYTE_W-1:0]      tx_shift_reg;
  logic [BYTE_W-1:0]      tx_shift_next;
  logic                   tx_active_reg;
  logic                   tx_active_next;
  logic                   sdo_reg;
  logic                   sdo_next;
  logic                   overrun_reg;
  logic                   overrun_next;
  logic                   frame_end_reg;
  logic                   frame_end_next;
  logic                   frame_accept_reg;
  logic                   frame_accept_next;
  logic                   wel_reg;
  logic                   wel_next;
  logic                   wip_reg;
  logic                   wip_next;

  logic                   sclk_rise;
  logic                   sclk_fall;
  logic                   cs_fall;
  logic                   push_valid;
  logic [RX_WORD_W-1:0]   push_data;
  logic                   push_ready;
  logic [RX_WORD_W-1:0]   pop_data;

  // [RL16] same edges, either idle level
  assign sclk_rise = sclk_s && !sclk_prev_reg;
  assign sclk_fall = !sclk_s && sclk_prev_reg;
  // [RL11] edge-sensitive select
  assign cs_fall   = !cs_n_s && cs_prev_reg;

  always_comb
  begin
    state_next        = state_reg;
    sclk_prev_next    = sclk_s;
    cs_prev_next      = cs_n_s;
    rx_shift_next     = rx_shift_reg;
    bit_cnt_next      = bit_cnt_reg;
    first_byte_next   = first_byte_reg;
    tx_shift_next     = tx_shift_reg;
    tx_active_next    = tx_active_reg;
    sdo_next          = sdo_reg;
    overrun_next      = overrun_reg;
    frame_end_next    = 1'b0;
    frame_accept_next = 1'b0;
    push_valid        = 1'b0;
    push_data         = {first_byte_reg, rx_shift_reg[BYTE_W-2:0], sdi_s};
    o_tx_ready        = 1'b0;

    case (state_reg)
      ST_DESELECTED:
      begin
        // [RL10] wait for select fall
        if (cs_fall)
        begin
          // [RL9] select makes active
          state_next      = ST_ACTIVE;
          // [RL5] count from first rise
          bit_cnt_next    = BIT_CNT_RST;
          first_byte_next = 1'b1;
          tx_active_next  = 1'b0;
          overrun_next    = 1'b0;
        end
      end
      ST_ACTIVE, ST_IGNORE:
      begin
        if (cs_n_s)
        begin
          // [RL23] accept on byte boundary
          frame_end_next    = 1'b1;
          frame_accept_next = (state_reg == ST_ACTIVE) && (bit_cnt_reg == BIT_CNT_RST)
                              && !first_byte_reg;
          state_next        = ST_DESELECTED;
          tx_active_next    = 1'b0;
        end
        else if (state_reg == ST_ACTIVE && !hold_n_s && !sclk_s)
        begin
          // [RL21] hold only with clock low
          // [RL12] bit count kept
          state_next = ST_HOLD;
        end
        else if (state_reg == ST_ACTIVE && i_cmd_reject)
        begin
          // [RL24] ignore until deselect
          state_next     = ST_IGNORE;
          tx_active_next = 1'b0;
        end
        else if (state_reg == ST_ACTIVE && sclk_rise)
        begin
          // [RL1] sample on rising edge
          // [RL3] shift in MSB first
          rx_shift_next = {rx_shift_reg[BYTE_W-2:0], sdi_s};
          bit_cnt_next  = bit_cnt_reg + 1'b1;
          if (bit_cnt_reg == BIT_CNT_LAST)
          begin
            push_valid      = 1'b1;
            first_byte_next = 1'b0;
            if (!push_ready)
            begin
              overrun_next = 1'b1;
            end
          end
        end
        else if (state_reg == ST_ACTIVE && sclk_fall)
        begin
          // [RL2] output changes after fall
          if (bit_cnt_reg == BIT_CNT_RST && !first_byte_reg)
          begin
            // [RL6] load after whole instruction
            o_tx_ready = 1'b1;
            if (i_tx_valid)
            begin
              // [RL4] send MSB first
              sdo_next       = i_tx_data[BYTE_W-1];
              tx_shift_next  = {i_tx_data[BYTE_W-2:0], 1'b0};
              tx_active_next = 1'b1;
            end
            else
            begin
              tx_active_next = 1'b0;
            end
          end
          else if (tx_active_reg)
          begin
            sdo_next      = tx_shift_reg[BYTE_W-1];
            tx_shift_next = {tx_shift_reg[BYTE_W-2:0], 1'b0};
          end
        end
      end
      ST_HOLD:
      begin
        // [RL13] clock and data ignored
        if (cs_n_s)
        begin
          // [RL22] deselect in hold resets
          frame_end_next = 1'b1;
          state_next     = ST_DESELECTED;
          tx_active_next = 1'b0;
          bit_cnt_next   = BIT_CNT_RST;
          rx_shift_next  = SHIFT_RST;
        end
        else if (hold_n_s && !sclk_s)
        begin
          // [RL25] resume at same bit
          state_next = ST_ACTIVE;
        end
      end
      default:
      begin
        state_next = ST_DESELECTED;
      end
    endcase
  end

  // [RL18] volatile status bits, set wins over clear
  always_comb
  begin
    wel_next = wel_reg;
    if (i_wel_clr)
    begin
      wel_next = 1'b0;
    end
    if (i_wel_set)
    begin
      wel_next = 1'b1;
    end
    wip_next = wip_reg;
    if (i_write_done)
    begin
      wip_next = 1'b0;
    end
    if (i_write_start)
    begin
      wip_next = 1'b1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      // [RL18] come up deselected
      state_reg        <= ST_DESELECTED;
      sclk_prev_reg    <= 1'b0;
      cs_prev_reg      <= CS_PREV_RST;
      rx_shift_reg     <= SHIFT_RST;
      bit_cnt_reg      <= BIT_CNT_RST;
      first_byte_reg   <= 1'b1;
      tx_shift_reg     <= SHIFT_RST;
      tx_active_reg    <= 1'b0;
      sdo_reg          <= 1'b0;
      overrun_reg      <= 1'b0;
      frame_end_reg    <= 1'b0;
      frame_accept_reg <= 1'b0;
      wel_reg          <= WEL_RST;
      wip_reg          <= WIP_RST;
    end
    else
    begin
      state_reg        <= state_next;
      sclk_prev_reg    <= sclk_prev_next;
      cs_prev_reg      <= cs_prev_next;
      rx_shift_reg     <= rx_shift_next;
      bit_cnt_reg      <= bit_cnt_next;
      first_byte_reg   <= first_byte_next;
      tx_shift_reg     <= tx_shift_next;
      tx_active_reg    <= tx_active_next;
      sdo_reg          <= sdo_next;
      overrun_reg      <= overrun_next;
      frame_end_reg    <= frame_end_next;
      frame_accept_reg <= frame_accept_next;
      wel_reg          <= wel_next;
      wip_reg          <= wip_next;
    end
  end

  // Received bytes wait here; a byte arriving while the buffer is full is dropped and sets overrun.
  spi_fe_buf #(
    .WIDTH (RX_WORD_W),
    .DEPTH (DEPTH)
  ) u_rx_buf (
    .i_clk       (i_clk),
    .i_resetn    (i_resetn),
    .i_in_valid  (push_valid),
    .i_in_data   (push_data),
    .o_in_ready  (push_ready),
    .o_out_valid (o_rx_valid),
    .o_out_data  (pop_data),
    .i_out_ready (i_rx_ready)
  );

  assign o_rx_first = pop_data[RX_WORD_W-1];
  assign o_rx_data  = pop_data[BYTE_W-1:0];

  // [RL7] float unless driving data
  assign o_sdo_oe_n = !((state_reg == ST_ACTIVE) && tx_active_reg);
  assign o_sdo      = sdo_reg;

  assign o_rx_overrun   = overrun_reg;
  assign o_frame_end    = frame_end_reg;
  assign o_frame_accept = frame_accept_reg;

  assign o_write_enable_latch = wel_reg;
  assign o_write_in_progress  = wip_reg;
  // [RL19] non-volatile bits pass through
  assign o_block_protect      = {i_block_protect_hi, i_block_protect_lo};
  // [RL15] write protect freezes protection
  assign o_protect_frozen     = i_status_write_disable && !wp_n_s;
  assign o_selected           = (state_reg != ST_DESELECTED);
  // [RL8] standby unless write running
  assign o_standby            = (state_reg == ST_DESELECTED) && !wip_reg;

endmodule
`default_nettype wire

// file: rtl/spi_fe_pkg.sv
// Shared constants and types for the serial memory front end.
//
// Function
// [RL1] Sample serial input on clock rising edges
// [RL2] Change serial output after clock falling edges
// [RL3] Input bytes arrive most significant bit first
// [RL4] Output bytes leave most significant bit first
// [RL5] First sample follows select going low
// [RL6] Read data starts after instruction byte
// [RL7] Deselected means serial output floats
// [RL8] Standby when deselected unless writing
// [RL9] Select low makes device active
// [RL10] Ignore bus until first select fall
// [RL11] Select low at power-up does nothing
// [RL12] Hold pauses, keeps bit position
// [RL13] Hold floats output, ignores clock, data
// [RL14] Master holds only while selected
// [RL15] Write protect freezes block protect bits
// [RL16] Clock modes zero and three supported
// [RL17] Modes differ only in idle clock
// [RL18] Reset clears write latch and busy
// [RL19] Non-volatile status bits survive reset
// [RL20] Master deselects before removing supply
// [RL21] Hold starts only with clock low
// [RL22] Deselect in hold resets interface logic
// [RL23] Accept instruction only on byte boundary
// [RL24] Unknown instruction ignored until deselect
// [RL25] Hold ends with clock low, resumes
package spi_fe_pkg;

  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned BIT_CNT_W  = 3;
  localparam int unsigned RX_WORD_W  = BYTE_W + 1;
  localparam int unsigned BUF_DEPTH  = 2;
  localparam int unsigned SYNC_W     = 5;

  localparam logic [BIT_CNT_W-1:0] BIT_CNT_RST  = 3'h0;
  localparam logic [BIT_CNT_W-1:0] BIT_CNT_LAST = 3'h7;
  localparam logic [BYTE_W-1:0]    SHIFT_RST    = 8'h00;
  localparam logic                 WEL_RST      = 1'b0;
  localparam logic                 WIP_RST      = 1'b0;
  localparam logic                 CS_PREV_RST  = 1'b0;

  typedef enum logic [1:0] {
    ST_DESELECTED,
    ST_ACTIVE,
    ST_HOLD,
    ST_IGNORE
  } fe_state_e;

endpackage

// file: rtl/spi_fe_sync.sv
// Two-stage synchroniser for a group of pin inputs.
`timescale 1ns/100ps
`default_nettype none
module spi_fe_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             i_clk,
  input  wire logic             i_resetn,
  input  wire logic [WIDTH-1:0] i_async,
  input  wire logic [WIDTH-1:0] i_rst_val,
  output var  logic [WIDTH-1:0] o_sync
);

  initial
  begin
    if (WIDTH < 1)
    begin
      $error("spi_fe_sync: WIDTH must be at least 1");
    end
  end

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      logic meta_reg;
      logic meta_next;
      logic sync_reg;
      logic sync_next;

      always_comb
      begin
        meta_next = i_async[g];
        sync_next = meta_reg;
      end

      always_ff @(posedge i_clk)
      begin
        if (!i_resetn)
        begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
        end
        else
        begin
          meta_reg <= meta_next;
          sync_reg <= sync_next;
        end
      end

      assign o_sync[g] = i_resetn ? sync_reg : i_rst_val[g];
    end
  endgenerate

endmodule
`default_nettype wire

// file: rtl/spi_fe_buf.sv
// Small valid/ready buffer for received bytes.
`timescale 1ns/100ps
`default_nettype none
module spi_fe_buf #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 2
) (
  input  wire logic             i_clk,
  input  wire logic             i_resetn,
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output var  logic             o_in_ready,
  output var  logic             o_out_valid,
  output var  logic [WIDTH-1:0] o_out_data,
  input  wire logic             i_out_ready
);

  localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial
  begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin
      $error("spi_fe_buf: DEPTH must be a power of two, at least 2");
    end
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] wr_ptr_next;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_next;
  logic [PTR_W:0]   count_reg;
  logic [PTR_W:0]   count_next;
  logic             push;
  logic             pop;

  always_comb
  begin
    o_in_ready  = (count_reg != (PTR_W+1)'(DEPTH));
    o_out_valid = (count_reg != '0);
    o_out_data  = mem_reg[rd_ptr_reg];
    push        = i_in_valid && o_in_ready;
    pop         = o_out_valid && i_out_ready;
    wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
    rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
    count_next  = count_reg;
    if (push && !pop)
    begin
      count_next = count_reg + 1'b1;
    end
    else if (pop && !push)
    begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg  <= count_next;
    end
    if (push)
    begin
      mem_reg[wr_ptr_reg] <= i_in_data;
    end
  end

endmodule
`default_nettype wire

// file: testbench/spi_fe_props.sv
// Port-level assertions for the serial front end.
`timescale 1ns/100ps
`default_nettype none
module spi_fe_props (
  input wire logic       i_clk,
  input wire logic       i_resetn,
  input wire logic       i_sclk,
  input wire logic       i_cs_n,
  input wire logic       i_hold_n,
  input wire logic       i_wp_n,
  input wire logic       i_tx_valid,
  input wire logic       i_status_write_disable,
  input wire logic       i_block_protect_hi,
  input wire logic       i_block_protect_lo,
  input wire logic       o_sdo,
  input wire logic       o_sdo_oe_n,
  input wire logic       o_tx_ready,
  input wire logic       o_frame_end,
  input wire logic       o_frame_accept,
  input wire logic       o_rx_overrun,
  input wire logic       o_write_enable_latch,
  input wire logic       o_write_in_progress,
  input wire logic       o_protect_frozen,
  input wire logic [1:0] o_block_protect,
  input wire logic       o_selected,
  input wire logic       o_standby
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  property p_oe_desel; i_cs_n [*5] |-> o_sdo_oe_n; endproperty
  a_oe_desel: assert property (p_oe_desel) else $error("driving while deselected");
  property p_standby;
    (i_cs_n [*5] |-> o_standby == !o_write_in_progress) and (o_selected |-> !o_standby);
  endproperty
  a_standby: assert property (p_standby) else $error("standby wrong");
  property p_reset;
    $rose(i_resetn) |-> !o_selected && o_standby && !o_write_enable_latch
      && !o_write_in_progress && o_sdo_oe_n;
  endproperty
  a_reset: assert property (p_reset) else $error("bad state after reset");
  property p_bp; o_block_protect == {i_block_protect_hi, i_block_protect_lo}; endproperty
  a_bp: assert property (p_bp) else $error("protect bits altered");
  property p_frozen;
    $stable(i_wp_n) [*3] ##0 $past(i_resetn, 3)
      |-> o_protect_frozen == (i_status_write_disable && !i_wp_n);
  endproperty
  a_frozen: assert property (p_frozen) else $error("freeze flag wrong");
  property p_sdo_fall;
    !o_sdo_oe_n && !$past(o_sdo_oe_n) && $changed(o_sdo) |-> !$past(i_sclk) && !$past(i_sclk, 2);
  endproperty
  a_sdo_fall: assert property (p_sdo_fall) else $error("output moved off falling edge");
  property p_hold; !i_cs_n && !i_hold_n && !i_sclk ##1 !i_hold_n [*5] |-> o_sdo_oe_n; endproperty
  a_hold: assert property (p_hold) else $error("output driven in hold");
  property p_frame_end; o_frame_end |-> $past(i_cs_n) && $past(i_cs_n, 2) ##1 !o_frame_end; endproperty
  a_frame_end: assert property (p_frame_end) else $error("frame end misplaced");
  property p_tx_ready; o_tx_ready |-> !i_sclk && !$past(i_sclk) ##1 !o_tx_ready; endproperty
  a_tx_ready: assert property (p_tx_ready) else $error("load request off falling edge");
  c_accept: cover property (o_frame_end && o_frame_accept);
  c_overrun: cover property (o_rx_overrun);
  c_hold: cover property (!i_hold_n && o_selected && o_sdo_oe_n);
  c_tx: cover property (o_tx_ready && i_tx_valid);
endmodule
`default_nettype wire

// file: testbench/spi_master_model.sv
// Behavioural SPI bus master driving the front end's pins.
`timescale 1ns/100ps
`default_nettype none
module spi_master_model (
  input  wire logic i_sdo,
  output var  logic o_sclk,
  output var  logic o_sdi,
  output var  logic o_cs_n,
  output var  logic o_hold_n
);
  localparam time HALF = 80ns;
  logic cpol;
  initial
  begin
    o_sclk = 1'b0;
    o_sdi = 1'b0;
    o_cs_n = 1'b0;
    o_hold_n = 1'b1;
    cpol = 1'b0;
  end
  task automatic sel(input logic pol);
    cpol = pol;
    o_sclk = pol;
    #HALF;
    o_cs_n = 1'b0;
    #HALF;
  endtask
  task automatic bit1(input logic b, output logic r);
    o_sclk = 1'b0;
    o_sdi = b;
    #HALF;
    o_sclk = 1'b1;
    #HALF;
    r = i_sdo;
  endtask
  task automatic hold(input logic kill);
    o_sclk = 1'b0;
    #HALF;
    o_hold_n = 1'b0;
    repeat (3)
    begin
      #HALF;
      o_sclk = 1'b1;
      o_sdi = ~o_sdi;
      #HALF;
      o_sclk = 1'b0;
    end
    #HALF;
    if (kill)
      o_cs_n = 1'b1;
    #HALF;
    o_hold_n = 1'b1;
    #HALF;
  endtask
  task automatic desel();
    o_sclk = cpol;
    #HALF;
    o_cs_n = 1'b1;
    o_sdi = ~o_sdi;
    #(2 * HALF);
  endtask
endmodule
`default_nettype wire

// file: testbench/spi_fe_top_test.sv
// Self-checking bench for the serial front end.
`timescale 1ns/100ps
`default_nettype none
module spi_fe_top_test;
  import spi_fe_pkg::*;
  logic i_clk = 1'b0, i_resetn = 1'b0, i_rx_ready = 1'b0, i_tx_valid = 1'b1;
  logic i_cmd_reject = 1'b0, i_wel_set = 1'b0, i_wel_clr = 1'b0, i_write_start = 1'b0;
  logic i_write_done = 1'b0, i_status_write_disable = 1'b0, i_wp_n = 1'b1;
  logic i_block_protect_hi = 1'b0, i_block_protect_lo = 1'b0;
  logic [BYTE_W-1:0] i_tx_data = 8'hA5;
  logic [BYTE_W-1:0] o_rx_data;
  logic [1:0] o_block_protect;
  logic o_sdo, o_sdo_oe_n, o_rx_valid, o_rx_first, o_rx_overrun, o_tx_ready, o_frame_end;
  logic o_frame_accept, o_write_enable_latch, o_write_in_progress, o_protect_frozen;
  logic o_selected, o_standby, rdy_en = 1'b1, rej_en = 1'b0, ewel, ewip, fe_acc;
  logic i_sclk, i_sdi, i_cs_n, i_hold_n, s;
  // A released data line reads as the inverse of the last driven bit.
  wire logic sdo_line = o_sdo_oe_n ? ~o_sdo : o_sdo;
  int errors = 0, n_compared = 0, fe_cnt = 0;
  logic [8:0] eq[$], gq[$];
  logic [7:0] txq[$];

  initial
  begin
    forever #10 i_clk = ~i_clk;
  end
  spi_master_model u_spi_master_model (.i_sdo(sdo_line), .o_sclk(i_sclk), .o_sdi(i_sdi),
    .o_cs_n(i_cs_n), .o_hold_n(i_hold_n));
  spi_fe_top #(.DEPTH(BUF_DEPTH)) u_spi_fe_top (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_sclk(i_sclk), .i_sdi(i_sdi), .i_cs_n(i_cs_n), .i_hold_n(i_hold_n), .i_wp_n(i_wp_n),
    .o_sdo(o_sdo), .o_sdo_oe_n(o_sdo_oe_n), .o_rx_valid(o_rx_valid), .o_rx_data(o_rx_data),
    .o_rx_first(o_rx_first), .i_rx_ready(i_rx_ready), .o_rx_overrun(o_rx_overrun),
    .i_tx_valid(i_tx_valid), .i_tx_data(i_tx_data), .o_tx_ready(o_tx_ready),
    .i_cmd_reject(i_cmd_reject), .o_frame_end(o_frame_end), .o_frame_accept(o_frame_accept),
    .i_wel_set(i_wel_set), .i_wel_clr(i_wel_clr), .i_write_start(i_write_start),
    .i_write_done(i_write_done), .i_status_write_disable(i_status_write_disable),
    .i_block_protect_hi(i_block_protect_hi), .i_block_protect_lo(i_block_protect_lo),
    .o_write_enable_latch(o_write_enable_latch), .o_write_in_progress(o_write_in_progress),
    .o_protect_frozen(o_protect_frozen), .o_block_protect(o_block_protect),
    .o_selected(o_selected), .o_standby(o_standby));

  task automatic check(input string nm, input logic [8:0] seen, input logic [8:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("errors %0d n_compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Monitor, stimulus of the side ports and the status-bit model.
  always @(posedge i_clk)
  begin
    if (o_rx_valid && i_rx_ready)
      gq.push_back({o_rx_first, o_rx_data});
    if (o_tx_ready && i_tx_valid)
    begin
      txq.push_back(i_tx_data);
      i_tx_data <= 8'($urandom);
    end
    if (o_frame_end)
    begin
      fe_cnt <= fe_cnt + 1;
      fe_acc <= o_frame_accept;
    end
    i_rx_ready <= rdy_en & 1'($urandom);
    i_cmd_reject <= rej_en & o_rx_valid & o_rx_first;
    {i_wel_set, i_wel_clr, i_write_start, i_write_done} <= 4'($urandom);
    if ($urandom % 32 == 0)
      {i_status_write_disable, i_block_protect_hi, i_block_protect_lo, i_wp_n} <= 4'($urandom);
    ewel <= i_resetn && (i_wel_set || (ewel && !i_wel_clr));
    ewip <= i_resetn && (i_write_start || (ewip && !i_write_done));
  end
  always @(negedge i_clk)
  begin
    check("write_enable_latch", 9'(o_write_enable_latch), 9'(ewel));
    check("write_in_progress", 9'(o_write_in_progress), 9'(ewip));
  end

  task automatic frame(input int cp, nb, ha, kill, keep, acc, chk, ovr);
    logic [7:0] b;
    logic [7:0] r;
    int         n0;
    @(posedge i_clk);
    #7;
    n0 = fe_cnt;
    txq.delete();
    u_spi_master_model.sel(cp[0]);
    for (int k = 0; k < nb; k++)
    begin
      if (k % 8 == 0)
        b = 8'($urandom);
      if (k == ha)
        u_spi_master_model.hold(kill[0]);
      if (kill != 0 && k == ha)
        break;
      u_spi_master_model.bit1(b[7 - k % 8], s);
      r[7 - k % 8] = s;
      if (k % 8 == 7 && k / 8 < keep)
        eq.push_back({k == 7, b});
      if (k % 8 == 7 && k > 7 && chk != 0)
        check("tx_byte", {1'b0, r}, {1'b0, txq.pop_front()});
    end
    u_spi_master_model.desel();
    for (int w = 0; w < 100 && fe_cnt == n0; w++)
      @(posedge i_clk);
    if (fe_cnt == n0)
    begin
      errors++;
      final_report();
    end
    check("frame_accept", 9'(fe_acc), 9'(acc));
    check("rx_overrun", 9'(o_rx_overrun), 9'(ovr));
    rdy_en = 1'b1;
    repeat (30) @(posedge i_clk);
    check("rx_count", 9'(gq.size()), 9'(eq.size()));
    while (eq.size() > 0 && gq.size() > 0)
      check("rx_byte", gq.pop_front(), eq.pop_front());
    eq.delete();
    gq.delete();
  endtask

  initial
  begin
    void'($urandom(42117));
    repeat (12) @(posedge i_clk);
    i_resetn <= 1'b1;
    repeat (4) @(posedge i_clk);
    #7;
    for (int k = 0; k < 8; k++)
      u_spi_master_model.bit1(1'b1, s);
    check("selected", 9'(o_selected), 9'h000);
    check("rx_count", 9'(gq.size()), 9'h000);
    u_spi_master_model.desel();
    for (int cp = 0; cp < 2; cp++)
      frame(cp, 24, -1, 0, 3, 1, 1, 0);
    // Hold in the middle of an outgoing byte, so the output must float and resume.
    frame(0, 16, 12, 0, 2, 1, 1, 0);
    frame(1, 16, 4, 1, 0, 0, 0, 0);
    frame(0, 12, -1, 0, 1, 0, 1, 0);
    rej_en = 1'b1;
    frame(1, 24, -1, 0, 1, 0, 0, 0);
    rej_en = 1'b0;
    rdy_en = 1'b0;
    frame(1, 24, -1, 0, 2, 1, 1, 1);
    final_report();
  end
endmodule

bind spi_fe_top spi_fe_props u_spi_fe_props (.i_clk(i_clk), .i_resetn(i_resetn),
  .i_sclk(i_sclk), .i_cs_n(i_cs_n), .i_hold_n(i_hold_n), .i_wp_n(i_wp_n),
  .i_tx_valid(i_tx_valid), .i_status_write_disable(i_status_write_disable),
  .i_block_protect_hi(i_block_protect_hi), .i_block_protect_lo(i_block_protect_lo),
  .o_sdo(o_sdo), .o_sdo_oe_n(o_sdo_oe_n), .o_tx_ready(o_tx_ready), .o_frame_end(o_frame_end),
  .o_frame_accept(o_frame_accept), .o_rx_overrun(o_rx_overrun),
  .o_write_enable_latch(o_write_enable_latch), .o_write_in_progress(o_write_in_progress),
  .o_protect_frozen(o_protect_frozen), .o_block_protect(o_block_protect),
  .o_selected(o_selected), .o_standby(o_standby));
`default_nettype wire
